// ### sar_converter_sequencer.sv
// Sequencer around a 10-bit successive approximation converter core.
// Assumes the core presents its result on core_result when the last
// converter clock period of a conversion ends, and that trigger flags are
// synchronous to mclk.
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"

module sar_converter_sequencer (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Trigger source flags, index picked by trigger_source_select
	input wire logic [7:0] trig_flags,
	// Converter core
	input wire logic [9:0] core_result,
	output logic [4:0] conv_channel,
	output logic [1:0] conv_reference,
	output logic [1:0] conv_gain,
	output logic conv_active,
	output logic conv_first,
	// Interrupt request
	output logic conv_irq
);

	sar_seq_pkg::state_t s_reg;
	sar_seq_pkg::state_t s_next;

	logic [7:0] div_m1;
	logic tick;
	logic trig_now;
	logic trig_edge;
	logic auto_fire;
	logic wr_csa;
	logic start_wr;
	logic conv_end;
	logic free_run;
	logic [4:0] conv_len;
	logic [7:0] low_view;
	logic [7:0] high_view;

	// Gain code from channel code
	function automatic sar_seq_pkg::gain_t gain_of(input logic [4:0] ch);
		sar_seq_pkg::gain_t g;
		g = sar_seq_pkg::GAIN_BYPASS;
		if (ch >= `CH_SINGLE_LO || ch < `CH_DIFF1_LO) begin
			g = sar_seq_pkg::GAIN_BYPASS;
		end else if (ch >= `CH_DIFF200_LO) begin
			g = sar_seq_pkg::GAIN_X200;
		end else if (ch >= `CH_DIFF10_LO) begin
			g = sar_seq_pkg::GAIN_X10;
		end else begin
			g = sar_seq_pkg::GAIN_X1;
		end
		return g;
	endfunction

	// Derived strobes
	always_comb begin
		// Divider of 2 << psc_sel, minus one
		div_m1 = 8'hFF >> (3'h7 - s_reg.psc_sel);
		tick = (s_reg.psc == div_m1);
		// source flags arrive set even when masked
		trig_now = trig_flags[s_reg.trig_sel];
		trig_edge = trig_now & ~s_reg.trig_prev;
		free_run = s_reg.auto_en && (s_reg.trig_sel == `TRIG_FREE);
		// auto start only while idle and enabled
		auto_fire = s_reg.enable && s_reg.auto_en && !free_run && trig_edge
			&& (s_reg.phase == sar_seq_pkg::PH_IDLE);
		wr_csa = reg_wr && (reg_addr == `OFS_CTRL_A);
		// start needs the power gate open
		start_wr = wr_csa && reg_wdata[`CSA_START] && reg_wdata[`CSA_ENABLE]
			&& !s_reg.gate && (s_reg.phase == sar_seq_pkg::PH_IDLE);
		// first conversion is the long one
		conv_len = s_reg.first ? `CONV_FIRST : `CONV_NORMAL;
		conv_end = (s_reg.phase == sar_seq_pkg::PH_CONV) && tick
			&& (s_reg.ticks == conv_len - 5'd1);
		// alignment of the two result bytes
		if (s_reg.left) begin
			high_view = s_reg.result[9:2];
			low_view = {s_reg.result[1:0], 6'h00};
		end else begin
			high_view = {6'h00, s_reg.result[9:8]};
			low_view = s_reg.result[7:0];
		end
	end

	// Next state
	always_comb begin
		s_next = s_reg;
		s_next.trig_prev = trig_now;
		s_next.rdata = 8'h00;

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				`OFS_CTRL_A: begin
					s_next.enable = reg_wdata[`CSA_ENABLE];
					s_next.auto_en = reg_wdata[`CSA_AUTO];
					s_next.irq_en = reg_wdata[`CSA_IRQ_EN];
					s_next.psc_sel = reg_wdata[2:0];
					if (reg_wdata[`CSA_DONE]) begin
						s_next.done = 1'b0;
					end
				end
				`OFS_CTRL_B: begin
					s_next.trig_sel = reg_wdata[2:0];
				end
				`OFS_CHAN_MUX: begin
					s_next.ref_sel = reg_wdata[`MUX_REF_LSB +: 2];
					s_next.left = reg_wdata[`MUX_LEFT];
					s_next.chan = reg_wdata[4:0];
				end
				`OFS_POWER_RED: begin
					s_next.gate = reg_wdata[`PRR_GATE];
				end
				default: begin
				end
			endcase
		end

		// Register reads, data stand one cycle later
		if (reg_rd) begin
			unique case (reg_addr)
				`OFS_RESULT_LOW: begin
					s_next.rdata = low_view;
					// low byte read locks the pair
					s_next.blocked = 1'b1;
				end
				`OFS_RESULT_HIGH: begin
					s_next.rdata = high_view;
					// high byte read releases the pair
					s_next.blocked = 1'b0;
				end
				`OFS_CTRL_A: begin
					s_next.rdata = {s_reg.enable, s_reg.phase != sar_seq_pkg::PH_IDLE,
						s_reg.auto_en, s_reg.done, s_reg.irq_en, s_reg.psc_sel};
				end
				`OFS_CTRL_B: begin
					s_next.rdata = {5'h00, s_reg.trig_sel};
				end
				`OFS_CHAN_MUX: begin
					s_next.rdata = {s_reg.ref_sel, s_reg.left, s_reg.chan};
				end
				`OFS_POWER_RED: begin
					s_next.rdata = {7'h00, s_reg.gate};
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end

		if (!s_reg.enable) begin
			s_next.psc = 8'h00;
		end else if (auto_fire) begin
			s_next.psc = 8'h00;
		end else if (tick) begin
			s_next.psc = 8'h00;
		end else begin
			s_next.psc = s_reg.psc + 8'h01;
		end

		// Each enable starts with a long conversion
		if (s_next.enable && !s_reg.enable) begin
			s_next.first = 1'b1;
		end

		// Conversion sequence
		unique case (s_reg.phase)
			sar_seq_pkg::PH_IDLE: begin
				if (start_wr || auto_fire) begin
					s_next.phase = sar_seq_pkg::PH_ARM;
				end
			end
			sar_seq_pkg::PH_ARM: begin
				// Conversion begins on the next converter clock
				if (tick) begin
					s_next.phase = sar_seq_pkg::PH_CONV;
					s_next.ticks = 5'd0;
				end
			end
			sar_seq_pkg::PH_CONV: begin
				if (tick) begin
					s_next.ticks = s_reg.ticks + 5'd1;
				end
				if (conv_end) begin
					if (!s_reg.blocked) begin
						s_next.result = core_result;
					end
					s_next.first = 1'b0;
					if (free_run) begin
						s_next.phase = sar_seq_pkg::PH_CONV;
						s_next.ticks = 5'd0;
					end else begin
						s_next.phase = sar_seq_pkg::PH_IDLE;
					end
				end
			end
			default: begin
				s_next.phase = sar_seq_pkg::PH_IDLE;
			end
		endcase

		// flag set wins over the clear
		if (conv_end) begin
			s_next.done = 1'b1;
		end

		// Disabling aborts any conversion in flight
		if (!s_next.enable) begin
			s_next.phase = sar_seq_pkg::PH_IDLE;
		end

		if (s_next.enable && (s_reg.phase != sar_seq_pkg::PH_CONV || conv_end)) begin
			s_next.act_chan = s_next.chan;
			s_next.act_ref = s_next.ref_sel;
			s_next.act_gain = gain_of(s_next.chan);
		end

		s_next.active = (s_next.phase == sar_seq_pkg::PH_CONV);
		s_next.irq = s_next.done && s_next.irq_en;
	end

	// State register; whole record resets to constants
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.psc_sel <= `RST_PSC_SEL;
			s_reg.trig_sel <= `RST_TRIG_SEL;
			s_reg.chan <= `RST_CHAN;
			s_reg.gate <= `RST_GATE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from the record
	assign reg_rdata = s_reg.rdata;
	assign conv_channel = s_reg.act_chan;
	assign conv_reference = s_reg.act_ref;
	assign conv_gain = s_reg.act_gain;
	assign conv_active = s_reg.active;
	assign conv_first = s_reg.first;
	assign conv_irq = s_reg.irq;

	// Checks
	logic seq_high_read_now;
	assign seq_high_read_now = reg_rd && (reg_addr == `OFS_RESULT_HIGH);

	sequence seq_low_read;
		reg_rd && (reg_addr == `OFS_RESULT_LOW);
	endsequence

	sequence seq_high_read;
		reg_rd && (reg_addr == `OFS_RESULT_HIGH);
	endsequence

	sequence seq_locked_end;
		s_reg.blocked && !seq_high_read_now && conv_end;
	endsequence

	chk_low_read_locks: assert property (@(posedge mclk) disable iff (rst)
		seq_low_read |=> s_reg.blocked)
		else $error("low byte read did not lock result");

	chk_locked_result_held: assert property (@(posedge mclk) disable iff (rst)
		seq_locked_end |=> $stable(s_reg.result))
		else $error("locked result was overwritten");

	chk_high_read_unlocks: assert property (@(posedge mclk) disable iff (rst)
		seq_high_read |=> !s_reg.blocked)
		else $error("high byte read did not unlock result");

	chk_flag_on_discard: assert property (@(posedge mclk) disable iff (rst)
		seq_locked_end |=> s_reg.done)
		else $error("done flag missing on discarded result");

	chk_start_reads_busy: assert property (@(posedge mclk) disable iff (rst)
		reg_rd && reg_addr == `OFS_CTRL_A |=>
		reg_rdata[`CSA_START] == ($past(s_reg.phase) != sar_seq_pkg::PH_IDLE))
		else $error("start bit does not show busy");

	chk_single_ends_idle: assert property (@(posedge mclk) disable iff (rst)
		conv_end && !free_run |=> s_reg.phase == sar_seq_pkg::PH_IDLE && s_reg.done)
		else $error("single conversion did not finish cleanly");

	chk_free_run_restart: assert property (@(posedge mclk) disable iff (rst)
		conv_end && free_run && s_next.enable |=> conv_active ##1 conv_active)
		else $error("free running did not restart");

	chk_channel_locked: assert property (@(posedge mclk) disable iff (rst)
		s_reg.phase == sar_seq_pkg::PH_CONV ##1 s_reg.phase == sar_seq_pkg::PH_CONV
		|-> $stable(conv_channel))
		else $error("channel changed during conversion");

	chk_psc_held_off: assert property (@(posedge mclk) disable iff (rst)
		!s_reg.enable |=> s_reg.psc == 8'h00 && !conv_active)
		else $error("prescaler ran while disabled");

	chk_busy_ignores_edge: assert property (@(posedge mclk) disable iff (rst)
		s_reg.phase == sar_seq_pkg::PH_CONV && !conv_end && s_next.enable
		|=> s_reg.phase == sar_seq_pkg::PH_CONV && $stable(s_reg.result))
		else $error("conversion disturbed while busy");

	chk_level_no_start: assert property (@(posedge mclk) disable iff (rst)
		s_reg.phase == sar_seq_pkg::PH_IDLE && trig_now && s_reg.trig_prev && !start_wr
		|=> s_reg.phase == sar_seq_pkg::PH_IDLE)
		else $error("held trigger level started a conversion");

	chk_irq_gated: assert property (@(posedge mclk) disable iff (rst)
		conv_end && s_next.irq_en |=> conv_irq)
		else $error("interrupt request missing after completion");

endmodule

// ### sar_converter_sequencer_tb_top.sv
// Directed testbench for the converter sequencer: register tasks and tests.
// Assumes the prescaler select stays 0, so one converter tick is 2 mclk cycles.
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"

module sar_converter_sequencer_tb_top;
	logic mclk, rst, reg_wr, reg_rd;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, trig_flags, d;
	logic [9:0] core_result;
	logic [4:0] conv_channel;
	logic [1:0] conv_reference, conv_gain;
	logic conv_active, conv_first, conv_irq;
	int err_total = 0;
	int total_checks = 0;
	int act_cnt = 0;
	int last_len = 0;
	int starts = 0;
	int s;
	logic [4:0] chans [5] = '{5'h03, 5'h08, 5'h10, 5'h18, 5'h1E};
	logic [1:0] gains [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};

	sar_converter_sequencer u_dut (
		.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_flags(trig_flags),
		.core_result(core_result), .conv_channel(conv_channel),
		.conv_reference(conv_reference), .conv_gain(conv_gain),
		.conv_active(conv_active), .conv_first(conv_first), .conv_irq(conv_irq)
	);

	// Free-running system clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Conversion length and start count, seen from the busy output
	always @(posedge mclk) begin
		if (conv_active === 1'b1) begin
			if (act_cnt == 0) starts <= starts + 1;
			act_cnt <= act_cnt + 1;
		end else if (act_cnt != 0) begin
			last_len <= act_cnt;
			act_cnt <= 0;
		end
	end

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data is taken one step after the edge that presents it
	task automatic rd(input logic [2:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Bounded wait on irq (sel 0) or busy (sel 1); a timeout is a mismatch
	task automatic wait_for(input int sel, input logic lvl, input int lim);
		int n;
		n = 0;
		while (((sel == 0) ? conv_irq : conv_active) !== lvl && n < lim) begin
			@(posedge mclk);
			#1 n++;
		end
		chk(sel == 0 ? "conv_irq" : "conv_active", (sel == 0) ? conv_irq : conv_active, lvl);
	endtask

	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, far beyond a few thousand cycles
	initial begin
		#750000;
		err_total++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		trig_flags = 8'h00;
		core_result = 10'h2A5;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(`OFS_CTRL_A);
		chk("ctrl_a reset", d, 8'h00);
		rd(3'h6);
		chk("unmapped read", d, 8'h00);
		// Selections wait for the enable bit
		wr(`OFS_CHAN_MUX, 8'h07);
		settle();
		chk("chan disabled", conv_channel, 5'h00);
		wr(`OFS_CTRL_A, 8'h80);
		settle();
		chk("chan enabled", conv_channel, 5'h07);
		for (int i = 0; i < 5; i++) begin
			wr(`OFS_CHAN_MUX, {3'h0, chans[i]});
			settle();
			chk("gain", conv_gain, gains[i]);
		end
		// Start refused while the power gate is set
		wr(`OFS_POWER_RED, 8'h01);
		wr(`OFS_CTRL_A, 8'hC8);
		settle();
		chk("gated busy", conv_active, 1'b0);
		rd(`OFS_CTRL_A);
		chk("gated start", d[6], 1'b0);
		wr(`OFS_POWER_RED, 8'h00);
		// First single conversion, channel change mid-way
		wr(`OFS_CHAN_MUX, 8'h03);
		wr(`OFS_CTRL_A, 8'hC8);
		rd(`OFS_CTRL_A);
		chk("start busy", d[6], 1'b1);
		wait_for(1, 1'b1, 10);
		wr(`OFS_CHAN_MUX, 8'h05);
		settle();
		chk("chan held", conv_channel, 5'h03);
		wait_for(0, 1'b1, 120);
		settle();
		chk("first len", last_len, 16'd50);
		chk("chan applied", conv_channel, 5'h05);
		rd(`OFS_CTRL_A);
		chk("start cleared", d[6], 1'b0);
		chk("done set", d[4], 1'b1);
		rd(`OFS_RESULT_LOW);
		chk("low right", d, 8'hA5);
		rd(`OFS_RESULT_HIGH);
		chk("high right", d, 8'h02);
		wr(`OFS_CHAN_MUX, 8'h25);
		rd(`OFS_RESULT_LOW);
		chk("low left", d, 8'h40);
		rd(`OFS_RESULT_HIGH);
		chk("high left", d, 8'hA9);
		wr(`OFS_CTRL_A, 8'h98);
		settle();
		chk("irq cleared", conv_irq, 1'b0);
		// Low read locks; a completion meanwhile is lost but still flagged
		rd(`OFS_RESULT_LOW);
		core_result <= 10'h155;
		wr(`OFS_CTRL_A, 8'hC8);
		wait_for(0, 1'b1, 80);
		settle();
		chk("normal len", last_len, 16'd26);
		rd(`OFS_RESULT_LOW);
		chk("low locked", d, 8'h40);
		rd(`OFS_RESULT_HIGH);
		chk("high locked", d, 8'hA9);
		wr(`OFS_CTRL_A, 8'h98);
		wr(`OFS_CTRL_A, 8'hC8);
		wait_for(0, 1'b1, 80);
		rd(`OFS_RESULT_LOW);
		chk("low new", d, 8'h40);
		rd(`OFS_RESULT_HIGH);
		chk("high new", d, 8'h55);
		// Auto trigger on source 3: edges only, none while busy
		wr(`OFS_CTRL_A, 8'h98);
		wr(`OFS_CTRL_B, 8'h03);
		wr(`OFS_CTRL_A, 8'hA8);
		s = starts;
		trig_flags <= 8'h08;
		wait_for(1, 1'b1, 10);
		rd(`OFS_CTRL_A);
		chk("auto busy", d[6], 1'b1);
		trig_flags <= 8'h00;
		@(posedge mclk);
		trig_flags <= 8'h08;
		wait_for(0, 1'b1, 80);
		repeat (60) @(posedge mclk);
		chk("held trigger", starts, s + 1);
		wr(`OFS_CTRL_A, 8'hB8);
		trig_flags <= 8'h00;
		@(posedge mclk);
		trig_flags <= 8'h08;
		wait_for(0, 1'b1, 80);
		chk("fresh edge", starts, s + 2);
		wr(`OFS_CTRL_A, 8'hB8);
		wr(`OFS_CTRL_A, 8'hE8);
		wait_for(0, 1'b1, 80);
		chk("manual in auto", starts, s + 3);
		// Free running on the own done flag
		wr(`OFS_CTRL_A, 8'hB8);
		wr(`OFS_CTRL_B, 8'h00);
		wr(`OFS_CTRL_A, 8'hE8);
		wait_for(0, 1'b1, 80);
		wr(`OFS_CTRL_A, 8'hB8);
		wait_for(0, 1'b0, 4);
		wait_for(0, 1'b1, 80);
		rd(`OFS_CTRL_A);
		chk("free busy", d[6], 1'b1);
		wr(`OFS_CTRL_A, 8'h00);
		settle();
		chk("disabled", conv_active, 1'b0);
		report_and_stop();
	end
endmodule

// ### sar_seq_cfg.svh
// Constants for the converter sequencer: register offsets, field positions,
// reset values and conversion lengths in converter clock periods.
// Assumes an 8-bit register port and a 40 MHz system clock.
//
// Operation
// - 10-bit result, right aligned unless left select
// - Low byte read blocks result updates
// - Blocked completion leaves result bytes untouched
// - High byte read re-enables result updates
// - Done flag still set when result discarded
// - Power gate clear plus start write converts
// - Start bit high until conversion completes
// - Channel change waits for current conversion end
// - Auto trigger enable with selectable source
// - Trigger rising edge resets prescaler, starts
// - Trigger level held high starts nothing
// - Trigger edges during conversion are ignored
// - Source flags set regardless of interrupt masks
// - Own done flag as trigger free-runs
// - Manual start works; start reads busy
// - Selections take effect only when enabled
// - Five-bit channel field: pins, ground, bandgap
// - Gain bypassed single-ended; differential 1x/10x/200x
// - 13 converter clocks, first one 25
// - Completion writes result, sets flag, clears start
// - Prescaler runs when enabled, reset otherwise
`ifndef SAR_SEQ_CFG_SVH
`define SAR_SEQ_CFG_SVH

// Register offsets
`define OFS_RESULT_LOW 3'h0
`define OFS_RESULT_HIGH 3'h1
`define OFS_CTRL_A 3'h2
`define OFS_CTRL_B 3'h3
`define OFS_CHAN_MUX 3'h4
`define OFS_POWER_RED 3'h5

// control_status_a fields
`define CSA_ENABLE 7
`define CSA_START 6
`define CSA_AUTO 5
`define CSA_DONE 4
`define CSA_IRQ_EN 3
// channel_mux_register fields
`define MUX_LEFT 5
`define MUX_REF_LSB 6
// power_reduction_reg field
`define PRR_GATE 0

// Reset values
`define RST_PSC_SEL 3'h0
`define RST_TRIG_SEL 3'h0
`define RST_CHAN 5'h00
`define RST_GATE 1'b0

// Trigger source code that selects the converter's own done flag
`define TRIG_FREE 3'h0

// Channel codes
`define CH_DIFF1_LO 5'h08
`define CH_DIFF10_LO 5'h10
`define CH_DIFF200_LO 5'h18
`define CH_SINGLE_LO 5'h1E

// Conversion lengths in converter clock periods
`define CONV_NORMAL 5'd13
`define CONV_FIRST 5'd25

`endif

// ### sar_seq_pkg.sv
// Types for the converter sequencer: phase enum, gain code, state record.
// Constants live in sar_seq_cfg.svh.
package sar_seq_pkg;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ARM = 2'b01,
		PH_CONV = 2'b10
	} phase_t;

	typedef enum logic [1:0] {
		GAIN_BYPASS = 2'b00,
		GAIN_X1 = 2'b01,
		GAIN_X10 = 2'b10,
		GAIN_X200 = 2'b11
	} gain_t;

	typedef struct packed {
		phase_t phase;
		logic [7:0] psc;
		logic [4:0] ticks;
		logic first;
		logic enable;
		logic auto_en;
		logic done;
		logic irq_en;
		logic [2:0] psc_sel;
		logic [2:0] trig_sel;
		logic [1:0] ref_sel;
		logic left;
		logic [4:0] chan;
		logic gate;
		logic [4:0] act_chan;
		logic [1:0] act_ref;
		gain_t act_gain;
		logic active;
		logic [9:0] result;
		logic blocked;
		logic trig_prev;
		logic [7:0] rdata;
		logic irq;
	} state_t;

endpackage
